// ---- common/etfs_pkg.sv ----
// etfs_pkg: constants, codes and timing for the edge timing function selector
// assumes a single 40 MHz clock domain and 16 channel slots
package etfs_pkg;
	localparam int ETFS_CHANS = 16; // i/o channel slots
	localparam int ETFS_PULSE_CHANS = 12; // pulse channel slots
	localparam int ETFS_DIGITS = 8; // digits per function word
	localparam int ETFS_DIGIT_W = 4; // one decimal digit per nibble
	localparam int ETFS_WORD_W = ETFS_DIGITS * ETFS_DIGIT_W; // function word width
	localparam int ETFS_RES_W = 32; // result width
	localparam int ETFS_IDX_W = 4; // channel index width
	localparam int ETFS_CLK_NS = 25; // clock period in ns
	localparam int ETFS_MS_NS = 1000000; // one millisecond in ns
	localparam int ETFS_MS_CYC = ETFS_MS_NS / ETFS_CLK_NS; // cycles per millisecond
	localparam int ETFS_FREQ_GATE_MS = 1000; // frequency gate, result in hz
	// function codes held in one digit
	typedef enum logic [2:0] {
		ETFS_FN_NONE = 3'h0,
		ETFS_FN_PERIOD = 3'h1,
		ETFS_FN_FREQ = 3'h2,
		ETFS_FN_PREV = 3'h3,
		ETFS_FN_FIRST = 3'h4,
		ETFS_FN_CNT_EXEC = 3'h5,
		ETFS_FN_CNT_FIRST = 3'h6
	} etfs_fn_t;
	localparam logic [3:0] ETFS_DIGIT_MAX = 4'h6; // highest legal digit
	localparam logic [ETFS_RES_W-1:0] ETFS_RES_ZERO = 32'h0; // cleared result
	localparam logic [ETFS_RES_W-1:0] ETFS_RES_ONE = 32'h1; // count step
endpackage

// ---- common/etfs_chan_if.sv ----
// etfs_chan_if: signals between the sequencer and one channel unit
// assumes both ends share ref_clk
`timescale 1ns/1ps
`default_nettype none
interface etfs_chan_if;
	import etfs_pkg::*;
	etfs_fn_t code; // latched function of the channel
	logic start; // execution start pulse
	logic tick; // millisecond tick
	logic own_edge; // edge on this channel
	logic prev_edge; // edge on the channel below
	logic first_edge; // edge on channel 1
	logic [ETFS_RES_W-1:0] result; // measured value
	logic valid; // result holds a value
	modport ctl (output code, start, tick, own_edge, prev_edge, first_edge, input result, valid);
	modport unit (input code, start, tick, own_edge, prev_edge, first_edge, output result, valid);
endinterface
`default_nettype wire

// ---- rtl/etfs_chan.sv ----
// etfs_chan: one channel measurement unit
// assumes start is a one cycle pulse from the sequencer and codes are already legalised
`timescale 1ns/1ps
`default_nettype none
module etfs_chan #(
	parameter int GATE_MS = etfs_pkg::ETFS_FREQ_GATE_MS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// sequencer side
	etfs_chan_if.unit u
);
	import etfs_pkg::*;
	typedef enum logic [1:0] {ETFS_CH_IDLE, ETFS_CH_ARM, ETFS_CH_RUN, ETFS_CH_DONE} etfs_ch_t;
	etfs_ch_t st_q, st_d; // unit state
	logic [ETFS_RES_W-1:0] cnt_q, cnt_d; // running measure
	logic [ETFS_RES_W-1:0] acc_q, acc_d; // edges since last execution
	logic [ETFS_RES_W-1:0] res_q, res_d; // held result
	logic [ETFS_RES_W-1:0] gate_q, gate_d; // frequency gate in ms
	logic trig; // arm condition met
	// arm trigger chosen by function
	always_comb begin
		unique case (u.code)
			ETFS_FN_PERIOD: trig = u.own_edge;
			ETFS_FN_PREV: trig = u.prev_edge;
			ETFS_FN_FIRST, ETFS_FN_CNT_FIRST: trig = u.first_edge;
			default: trig = 1'b1;
		endcase
	end
	// next state of the unit
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		res_d = res_q;
		gate_d = gate_q;
		acc_d = acc_q + (u.own_edge ? ETFS_RES_ONE : ETFS_RES_ZERO);
		if (u.start) begin
			cnt_d = ETFS_RES_ZERO;
			gate_d = ETFS_RES_ZERO;
			// every execution opens a new count window, whatever the code
			acc_d = u.own_edge ? ETFS_RES_ONE : ETFS_RES_ZERO; // new edge not lost
			if (u.code == ETFS_FN_NONE) begin
				st_d = ETFS_CH_IDLE;
			end else if (u.code == ETFS_FN_CNT_EXEC) begin
				res_d = acc_q;
				st_d = ETFS_CH_DONE;
			end else begin
				st_d = ETFS_CH_ARM;
			end
		end else begin
			unique case (st_q)
				ETFS_CH_IDLE, ETFS_CH_DONE: st_d = st_q;
				ETFS_CH_ARM: if (trig) st_d = ETFS_CH_RUN; // trig opens the window; for frequency trig is always set, so the window opens at once
				ETFS_CH_RUN: begin
					unique case (u.code)
						ETFS_FN_FREQ: begin
							cnt_d = cnt_q + (u.own_edge ? ETFS_RES_ONE : ETFS_RES_ZERO);
							gate_d = gate_q + (u.tick ? ETFS_RES_ONE : ETFS_RES_ZERO);
							if (gate_q == ETFS_RES_W'(GATE_MS)) begin
								res_d = cnt_q;
								st_d = ETFS_CH_DONE;
							end
						end
						ETFS_FN_CNT_FIRST: begin
							cnt_d = cnt_q + (u.own_edge ? ETFS_RES_ONE : ETFS_RES_ZERO);
							if (u.first_edge) begin
								res_d = cnt_q;
								st_d = ETFS_CH_DONE;
							end
						end
						default: begin
							cnt_d = cnt_q + (u.tick ? ETFS_RES_ONE : ETFS_RES_ZERO);
							if (u.own_edge) begin
								res_d = cnt_q;
								st_d = ETFS_CH_DONE;
							end
						end
					endcase
				end
			endcase
		end
	end
	// state registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= ETFS_CH_IDLE;
			cnt_q <= ETFS_RES_ZERO;
			acc_q <= ETFS_RES_ZERO;
			res_q <= ETFS_RES_ZERO;
			gate_q <= ETFS_RES_ZERO;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			acc_q <= acc_d;
			res_q <= res_d;
			gate_q <= gate_d;
		end
	end
	assign u.result = res_q;
	assign u.valid = (st_q == ETFS_CH_DONE);
	// execution count handed over at start
	cnt_exec_a: assert property (@(posedge ref_clk) disable iff (rst)
		u.start && u.code == ETFS_FN_CNT_EXEC |=> u.valid && u.result == $past(acc_q))
		else $error("count since last execution not returned");
	// time since channel 1 closes on own edge
	first_time_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_q == ETFS_CH_RUN && u.code == ETFS_FN_FIRST && u.own_edge && !u.start |=> u.valid)
		else $error("time since channel 1 not closed");
	// zero code never yields a value
	none_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		u.start && u.code == ETFS_FN_NONE |=> !u.valid)
		else $error("zero code produced a value");
endmodule // etfs_chan
`default_nettype wire

// ---- rtl/etfs_top.sv ----
// etfs_top: function selection, execution sequencing and ordered result output
// assumes inputs synchronous to ref_clk; start is a level or pulse from the controlling program
//
// Functional notes
// - codes zero none, one period, two frequency, three previous
// - code four: time from channel one edge
// - code five: pulse counts since last execution
// - code six: pulse count since channel one
// - first word sets channels 16-9 or 12-9
// - second word sets channels eight down to one
// - rightmost digit is lowest channel of word
// - omitted high digits read as zero
// - one result per nonzero code, ascending order
// - completion set only when all values present
// - held mode stalls sequencer until all done
`timescale 1ns/1ps
`default_nettype none
module etfs_top
	import etfs_pkg::*;
#(
	parameter int MS_CYC = etfs_pkg::ETFS_MS_CYC,
	parameter int GATE_MS = etfs_pkg::ETFS_FREQ_GATE_MS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// function words and options
	input wire logic [etfs_pkg::ETFS_WORD_W-1:0] fn_word_hi,
	input wire logic [etfs_pkg::ETFS_WORD_W-1:0] fn_word_lo,
	input wire logic pulse_set,
	input wire logic hold_mode,
	input wire logic start,
	// sensor inputs
	input wire logic [etfs_pkg::ETFS_CHANS-1:0] sig_in,
	// result stream
	output logic res_valid,
	output logic [etfs_pkg::ETFS_IDX_W-1:0] res_chan,
	output logic [etfs_pkg::ETFS_RES_W-1:0] res_data,
	// status
	output logic completion_indicator,
	output logic seq_stall,
	output logic busy
);
	import etfs_pkg::*;
	// refuse a tick rate the counter cannot serve
	if (MS_CYC < 2 || GATE_MS < 1) begin : g_bad_par
		$error("etfs_top: MS_CYC must be at least 2 and GATE_MS at least 1");
	end
	typedef enum logic [1:0] {ETFS_IDLE, ETFS_MEASURE, ETFS_EMIT} etfs_st_t;
	etfs_st_t st_q, st_d; // sequencer state
	etfs_fn_t code_q [ETFS_CHANS]; // latched codes
	etfs_fn_t code_d [ETFS_CHANS]; // codes taken at start
	logic [ETFS_IDX_W-1:0] idx_q, idx_d; // emit scan index
	logic done_q, done_d; // completion indicator
	logic [ETFS_RES_W-1:0] data_q, data_d; // output data
	logic [ETFS_IDX_W-1:0] chan_q, chan_d; // output channel index
	logic vld_q, vld_d; // output strobe
	logic [ETFS_CHANS-1:0] sig_q; // previous input level
	logic [ETFS_CHANS-1:0] edge_s; // rising edges
	logic [$clog2(MS_CYC)-1:0] ms_q; // millisecond divider
	logic tick; // one cycle per millisecond
	logic [ETFS_CHANS-1:0] ch_ok; // channel has a value or is unused
	logic [ETFS_RES_W-1:0] ch_res [ETFS_CHANS]; // channel results
	logic go; // execution accepted
	logic go_q; // start pulse one cycle after latch
	etfs_chan_if cif [ETFS_CHANS] ();
	// digit of channel i, hi word above channel eight
	function automatic etfs_fn_t chan_code(input int i, input logic [ETFS_WORD_W-1:0] hi,
		input logic [ETFS_WORD_W-1:0] lo, input logic pset);
		logic [ETFS_DIGIT_W-1:0] dg;
		dg = (i < ETFS_DIGITS) ? lo[i*ETFS_DIGIT_W +: ETFS_DIGIT_W]
			: hi[(i-ETFS_DIGITS)*ETFS_DIGIT_W +: ETFS_DIGIT_W];
		if (dg > ETFS_DIGIT_MAX) dg = 4'h0; // illegal digit measures nothing
		if (pset && i >= ETFS_PULSE_CHANS) dg = 4'h0;
		if (!pset && dg >= 4'h5) dg = 4'h0;
		return etfs_fn_t'(dg[2:0]);
	endfunction
	assign go = start && st_q == ETFS_IDLE;
	assign tick = (ms_q == ($clog2(MS_CYC))'(MS_CYC - 1));
	assign edge_s = sig_in & ~sig_q;
	// edge detect and millisecond divider
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sig_q <= '0;
			ms_q <= '0;
		end else begin
			sig_q <= sig_in;
			ms_q <= tick ? '0 : ms_q + 1'b1;
		end
	end
	// channel units, one per slot
	for (genvar g = 0; g < ETFS_CHANS; g++) begin : g_ch
		assign cif[g].code = code_q[g];
		assign cif[g].start = (st_q == ETFS_MEASURE) && (st_d == ETFS_MEASURE) && go_q;
		assign cif[g].tick = tick;
		assign cif[g].own_edge = edge_s[g];
		assign cif[g].prev_edge = (g == 0) ? 1'b0 : edge_s[(g == 0) ? 0 : g-1];
		assign cif[g].first_edge = edge_s[0];
		assign ch_ok[g] = cif[g].valid || code_q[g] == ETFS_FN_NONE;
		assign ch_res[g] = cif[g].result;
		etfs_chan #(.GATE_MS(GATE_MS)) u_chan (
			.ref_clk(ref_clk),
			.rst(rst),
			.u(cif[g])
		);
	end
	// sequencer next values
	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		done_d = done_q;
		vld_d = 1'b0;
		data_d = data_q;
		chan_d = chan_q;
		for (int i = 0; i < ETFS_CHANS; i++) begin
			code_d[i] = code_q[i];
		end
		unique case (st_q)
			ETFS_IDLE: if (start) begin
				done_d = 1'b0;
				for (int i = 0; i < ETFS_CHANS; i++) begin
					code_d[i] = chan_code(i, fn_word_hi, fn_word_lo, pulse_set);
				end
				st_d = ETFS_MEASURE;
			end
			ETFS_MEASURE: if (!go_q && &ch_ok) begin
				idx_d = '0;
				st_d = ETFS_EMIT;
			end
			ETFS_EMIT: begin
				if (code_q[idx_q] != ETFS_FN_NONE) begin
					vld_d = 1'b1;
					data_d = ch_res[idx_q];
					chan_d = idx_q;
				end
				idx_d = idx_q + 1'b1;
				if (idx_q == ETFS_IDX_W'(ETFS_CHANS - 1)) begin
					done_d = 1'b1;
					st_d = ETFS_IDLE;
				end
			end
		endcase
	end
	// sequencer registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= ETFS_IDLE;
			idx_q <= '0;
			done_q <= 1'b0;
			vld_q <= 1'b0;
			data_q <= ETFS_RES_ZERO;
			chan_q <= '0;
			go_q <= 1'b0;
			for (int i = 0; i < ETFS_CHANS; i++) begin
				code_q[i] <= ETFS_FN_NONE;
			end
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			done_q <= done_d;
			vld_q <= vld_d;
			data_q <= data_d;
			chan_q <= chan_d;
			go_q <= go;
			code_q <= code_d;
		end
	end
	assign res_valid = vld_q;
	assign res_chan = chan_q;
	assign res_data = data_q;
	assign completion_indicator = done_q;
	assign busy = (st_q != ETFS_IDLE);
	assign seq_stall = hold_mode && busy;
	// execution start then completion clear
	sequence start_seq;
		st_q == ETFS_IDLE && start;
	endsequence
	done_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		start_seq |=> !completion_indicator && cif[0].start)
		else $error("completion not cleared or units not started");
	// completion only after last channel scanned
	done_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(completion_indicator) |-> $past(st_q) == ETFS_EMIT && $past(&ch_ok))
		else $error("completion raised early");
	// emitted results ascend by channel
	emit_order_a: assert property (@(posedge ref_clk) disable iff (rst)
		res_valid && st_q == ETFS_EMIT ##1 res_valid |-> res_chan > $past(res_chan))
		else $error("results out of channel order");
	// only nonzero channels emit
	emit_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		res_valid |-> code_q[res_chan] != ETFS_FN_NONE)
		else $error("result for unused channel");
	// pulse set leaves top four slots unused
	pulse_span_a: assert property (@(posedge ref_clk) disable iff (rst)
		$past(go) && $past(pulse_set) |-> code_q[ETFS_PULSE_CHANS] == ETFS_FN_NONE
			&& code_q[ETFS_CHANS-1] == ETFS_FN_NONE)
		else $error("pulse set configured channel above 12");
	// lowest nibble selects channel 1
	digit_map_a: assert property (@(posedge ref_clk) disable iff (rst)
		go && fn_word_lo[3:0] == 4'h1 |=> code_q[0] == ETFS_FN_PERIOD)
		else $error("low digit not mapped to channel 1");
	// stall lasts through execution
	stall_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		hold_mode && st_q == ETFS_MEASURE |-> seq_stall && !completion_indicator)
		else $error("sequencer released before completion");
	// results leave only from the scan
	emit_window_a: assert property (@(posedge ref_clk) disable iff (rst)
		res_valid |-> $past(st_q) == ETFS_EMIT)
		else $error("result outside the scan");
	// lowest digit of the first word selects channel 9
	hi_map_a: assert property (@(posedge ref_clk) disable iff (rst)
		go && fn_word_hi[ETFS_DIGIT_W-1:0] == 4'h1 |=> code_q[ETFS_DIGITS] == ETFS_FN_PERIOD)
		else $error("first word not mapped to channel 9");
	// blank top digit leaves channel 8 unmeasured
	short_word_a: assert property (@(posedge ref_clk) disable iff (rst)
		go && fn_word_lo[ETFS_WORD_W-1 -: ETFS_DIGIT_W] == 4'h0 |=> code_q[ETFS_DIGITS-1] == ETFS_FN_NONE)
		else $error("omitted digit configured a channel");
	// completion stands until the next start
	done_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		completion_indicator && !start |=> completion_indicator)
		else $error("completion dropped without a start");
endmodule // etfs_top
`default_nettype wire

// ---- tb/etfs_sensor_model.sv ----
// etfs_sensor_model: free running square waves standing in for external sensors
// assumes ref_clk at 40 MHz; channel i toggles every 4*(i+1) cycles
`timescale 1ns/1ps
`default_nettype none
module etfs_sensor_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// sensor levels, bit0 = channel 1
	output logic [15:0] sig_out
);
	int cnt [16]; // per channel half period counters
	// each channel gets its own period so a wrong slot shows a wrong value
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sig_out <= 16'h0000;
			foreach (cnt[i]) cnt[i] <= 0;
		end else begin
			foreach (cnt[i]) begin
				if (cnt[i] == 4 * (i + 1) - 1) begin
					cnt[i] <= 0;
					sig_out[i] <= ~sig_out[i];
				end else begin
					cnt[i] <= cnt[i] + 1;
				end
			end
		end
	end
endmodule // etfs_sensor_model
`default_nettype wire

// ---- tb/etfs_top_tb_top.sv ----
// etfs_top_tb_top: self checking bench comparing the result stream with a queue model
// assumes MS_CYC 4 and GATE_MS 2 so that measurements finish quickly
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module etfs_top_tb_top;
	import etfs_pkg::*;
	logic ref_clk = 1'b0; // 40 MHz clock
	logic rst = 1'b1; // async reset
	logic [ETFS_WORD_W-1:0] fn_word_hi = 32'h0; // channels 16..9
	logic [ETFS_WORD_W-1:0] fn_word_lo = 32'h0; // channels 8..1
	logic pulse_set = 1'b0; // pulse channel set
	logic hold_mode = 1'b0; // constant instead of variable
	logic start = 1'b0; // execution start
	logic [ETFS_CHANS-1:0] sig_in; // sensor levels
	logic res_valid; // result strobe
	logic [ETFS_IDX_W-1:0] res_chan; // result channel
	logic [ETFS_RES_W-1:0] res_data; // result value
	logic completion_indicator; // all done
	logic seq_stall; // sequencer stalled
	logic busy; // execution running
	int n_errors = 0; // mismatches
	int num_checks = 0; // comparisons
	int exp_ch[$]; // expected channel order
	int exp_code[$]; // expected codes per result
	int edge_tot [ETFS_CHANS]; // rising edges seen since reset
	int edge_snap [ETFS_CHANS]; // edge totals at the previous execution
	logic [ETFS_CHANS-1:0] sig_prev; // levels at the previous edge
	// clock
	always #12.5 ref_clk = ~ref_clk;
	etfs_top #(.MS_CYC(4), .GATE_MS(2)) dut (.ref_clk(ref_clk), .rst(rst), .fn_word_hi(fn_word_hi),
		.fn_word_lo(fn_word_lo), .pulse_set(pulse_set), .hold_mode(hold_mode), .start(start),
		.sig_in(sig_in), .res_valid(res_valid), .res_chan(res_chan), .res_data(res_data),
		.completion_indicator(completion_indicator), .seq_stall(seq_stall), .busy(busy));
	etfs_sensor_model sensors (.ref_clk(ref_clk), .rst(rst), .sig_out(sig_in));
	// model: rising edges per channel, sampled as the design samples them
	always @(posedge ref_clk) begin
		sig_prev <= rst ? '0 : sig_in;
		foreach (edge_tot[i]) begin
			if (rst) edge_tot[i] <= 0;
			else if (sig_in[i] && !sig_prev[i]) edge_tot[i] <= edge_tot[i] + 1;
		end
	end
	// verdict and end of run
	task automatic results();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// model: which channels report, in which order, with which code
	task automatic build(input logic [31:0] hi, input logic [31:0] lo, input logic ps);
		int d;
		exp_ch.delete();
		exp_code.delete();
		for (int ch = 0; ch < ETFS_CHANS; ch++) begin // ascending order
			d = (ch < 8) ? lo[ch*4 +: 4] : hi[(ch-8)*4 +: 4]; // word split and digit order
			if (ps && ch >= ETFS_PULSE_CHANS) d = 0; // pulse set has 12 channels
			if (d > 6) d = 0;
			if (!ps && d >= 5) d = 0; // counts only on pulse set
			if (d != 0) begin // code zero gives nothing
				exp_ch.push_back(ch);
				exp_code.push_back(d);
			end
		end
	endtask
	// one execution: start, collect the stream, check completion
	task automatic run(input logic [31:0] hi, input logic [31:0] lo, input logic ps, input logic hm);
		int c;
		int e;
		int cnt5 [ETFS_CHANS];
		build(hi, lo, ps);
		@(posedge ref_clk);
		fn_word_hi <= hi;
		fn_word_lo <= lo;
		pulse_set <= ps;
		hold_mode <= hm;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		#1;
		`CHK(busy, 1'b1)
		`CHK(completion_indicator, 1'b0) // stale completion gone
		`CHK(seq_stall, hm)
		// edges between the previous execution and this one
		for (int i = 0; i < ETFS_CHANS; i++) begin
			cnt5[i] = edge_tot[i] - edge_snap[i];
			edge_snap[i] = edge_tot[i];
		end
		for (c = 0; c < 4000 && busy === 1'b1; c++) begin
			@(posedge ref_clk);
			start <= (c == 5); // start while busy is ignored
			#1;
			if (res_valid === 1'b1) begin
				`CHK(exp_ch.size() > 0, 1'b1) // no surplus results
				if (exp_ch.size() > 0) begin
					`CHK(res_chan, 4'(exp_ch[0]))
					e = 2 * (exp_ch[0] + 1);
					if (exp_code[0] == 5) `CHK(res_data, 32'(cnt5[exp_ch[0]]))
					else if (exp_code[0] == 1) `CHK(res_data >= e - 1 && res_data <= e + 1, 1'b1)
					else `CHK(res_data <= e + 1, 1'b1) // at most one own period
					`CHK(completion_indicator, 1'(exp_ch[0] == ETFS_CHANS - 1)) // rises with slot 16
					void'(exp_ch.pop_front());
					void'(exp_code.pop_front());
				end
			end
		end
		@(posedge ref_clk);
		start <= 1'b0;
		#1;
		`CHK(exp_ch.size(), 0) // every requested value came
		`CHK(completion_indicator, 1'b1)
		`CHK(seq_stall, 1'b0)
	endtask
	// watchdog
	initial begin
		#(25 * 100000);
		n_errors++;
		results();
	end
	// main sequence
	initial begin
		logic [31:0] hi;
		logic [31:0] lo;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		void'($urandom(65748));
		run(32'h0, 32'h00000211, 1'b0, 1'b0); // period, period, frequency
		run(32'h0, 32'h00004301, 1'b0, 1'b1); // previous and channel one timing
		run(32'h00006500, 32'h00000065, 1'b1, 1'b0); // counts on pulse set
		run(32'h56000000, 32'h00000560, 1'b0, 1'b1); // counts refused on i/o set
		run(32'h10000001, 32'h70000008, 1'b0, 1'b0); // top slot and illegal digits
		run(32'h11000010, 32'h00000001, 1'b1, 1'b0); // channels above 12 dropped
		for (int k = 0; k < 12; k++) begin
			hi = $urandom() & 32'h77777777;
			lo = $urandom() & 32'h77777777;
			if (lo[3:0] == 4'h3) lo[3:0] = 4'h1; // channel 1 has no channel below
			run(hi, lo, 1'($urandom()), 1'($urandom()));
		end
		results();
	end
endmodule // etfs_top_tb_top
`default_nettype wire
